// ### src/prx_mac_rx.sv
// Receive-side MII/RMII pin driver with reset-time strap capture
`timescale 1ns/1ps
module prx_mac_rx
  import prx_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [3:0] sym_nibble_in,
  input  wire logic       sym_err_in,
  input  wire logic       sym_valid_in,
  output logic            sym_ready_out,
  input  wire logic       rx_medium_active_in,
  input  wire logic       tx_medium_active_in,
  input  wire logic       speed_100_in,
  input  wire logic       full_duplex_in,
  input  wire logic       crossover_swap_in,
  input  wire logic [3:0] rxd_in,
  output logic      [3:0] rxd_out,
  output logic            rxd_oe_out,
  input  wire logic       rx_dv_in,
  output logic            rx_dv_out,
  output logic            rx_dv_oe_out,
  input  wire logic       rx_er_in,
  output logic            rx_er_out,
  output logic            rx_er_oe_out,
  input  wire logic       crs_in,
  output logic            crs_out,
  output logic            crs_oe_out,
  input  wire logic       col_in,
  output logic            col_out,
  output logic            col_oe_out,
  output logic            rx_clk_out,
  output logic            pair_speed_100_out,
  output logic            pair_swap_out,
  output logic [4:0]      phy_addr_out,
  output logic            rmii_mode_out,
  output logic            indicator_config_strap_out
);

  // ****************************************************************
  // Strap pin synchronisers
  // ****************************************************************
  logic [STRAP_W-1:0] strap_sync1_ff;
  logic [STRAP_W-1:0] strap_sync2_ff;
  logic [STRAP_W-1:0] strap_pins;

  assign strap_pins = {col_in, crs_in, rx_er_in, rx_dv_in, rxd_in};

  // Pins are only read while reset is high; the drivers are off from the first reset edge on
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      strap_sync1_ff <= strap_pins;
    end else begin
      strap_sync1_ff <= SYNC_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      strap_sync2_ff <= strap_sync1_ff;
    end else begin
      strap_sync2_ff <= SYNC_RST;
    end
  end

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  prx_strap_t strap_ff;
  prx_strap_t nxt_strap;

  always_comb begin
    nxt_strap.phy_addr               = {strap_sync2_ff[STRAP_ADDR_UP_LO +: 4],
                                        strap_sync2_ff[STRAP_ADDR0_POS]};
    nxt_strap.rmii_sel               = strap_sync2_ff[STRAP_RMII_POS];
    nxt_strap.auto_crossover_strap   = strap_sync2_ff[STRAP_XOVER_POS];
    nxt_strap.indicator_config_strap = strap_sync2_ff[STRAP_LEDCFG_POS];
  end

  logic rst_seen_ff;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rst_seen_ff <= 1'b1;
    end else begin
      rst_seen_ff <= 1'b0;
    end
  end

  // Sampled on every reset cycle after the first; the first loads STRAP_RST, address 0x01
  // Reset must span four edges: the first still sees driven pin levels
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in && rst_seen_ff) begin
      strap_ff <= nxt_strap;
    end else if (sys_rst_in) begin
      strap_ff <= STRAP_RST;
    end
  end

  assign phy_addr_out               = strap_ff.phy_addr;
  assign rmii_mode_out              = strap_ff.rmii_sel;
  assign indicator_config_strap_out = strap_ff.indicator_config_strap;

  // ****************************************************************
  // Pin drive enables
  // ****************************************************************
  logic drive_ff;

  // Off in reset so only the pulls set the strap levels
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= 1'b1;
    end
  end

  assign rxd_oe_out   = drive_ff;
  assign rx_dv_oe_out = drive_ff;
  assign rx_er_oe_out = drive_ff;
  assign crs_oe_out   = drive_ff;
  assign col_oe_out   = drive_ff;

  // ****************************************************************
  // Cable pair configuration
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pair_speed_100_out <= 1'b0;
    end else begin
      pair_speed_100_out <= speed_100_in;
    end
  end

  // Swap honoured only when the crossover strap allows it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pair_swap_out <= 1'b0;
    end else begin
      pair_swap_out <= strap_ff.auto_crossover_strap && crossover_swap_in;
    end
  end

  // ****************************************************************
  // Receive clock and output tick
  // ****************************************************************
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] tick_cnt_ff;
  logic [CNT_W-1:0] nxt_tick_cnt;
  logic             tick;
  logic             nxt_rx_clk;

  always_comb begin
    half = speed_100_in ? MII_HALF_100 : MII_HALF_10;
    if (strap_ff.rmii_sel) begin
      period = speed_100_in ? RMII_TICK_100 : RMII_TICK_10;
    end else begin
      period = CNT_W'({half, 1'b0});
    end
  end

  assign tick = (tick_cnt_ff == (strap_ff.rmii_sel ? (period - CNT_ONE) : (half - CNT_ONE)));

  // Wraps at or beyond the end so a speed change never strands it above the period
  always_comb begin
    if (tick_cnt_ff >= (period - CNT_ONE)) begin
      nxt_tick_cnt = CNT_ZERO;
    end else begin
      nxt_tick_cnt = tick_cnt_ff + CNT_ONE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tick_cnt_ff <= CNT_ZERO;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // High for the first half period, low for the second; data changes on the fall
  always_comb begin
    if (strap_ff.rmii_sel || !drive_ff) begin
      nxt_rx_clk = 1'b0;
    end else if (tick_cnt_ff >= (period - CNT_ONE)) begin
      nxt_rx_clk = 1'b1;
    end else if (tick) begin
      nxt_rx_clk = 1'b0;
    end else begin
      nxt_rx_clk = rx_clk_out;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_clk_out <= 1'b0;
    end else begin
      rx_clk_out <= nxt_rx_clk;
    end
  end

  // ****************************************************************
  // Receive FIFO
  // ****************************************************************
  prx_word_t fifo_wr;
  prx_word_t fifo_rd;
  logic      fifo_rd_valid;
  logic      fifo_rd_ready;
  logic      dibit_hi_ff;

  assign fifo_wr = '{nibble: sym_nibble_in, err: sym_err_in};

  prx_fifo #(
    .WIDTH ($bits(prx_word_t)),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_data_in   (fifo_wr),
    .wr_valid_in  (sym_valid_in),
    .wr_ready_out (sym_ready_out),
    .rd_data_out  (fifo_rd),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready)
  );

  // Nibble leaves the FIFO once fully shifted out: MII every tick, RMII on the high dibit tick
  assign fifo_rd_ready = tick && drive_ff && (!strap_ff.rmii_sel || dibit_hi_ff);

  // ****************************************************************
  // Receive data, valid and error
  // ****************************************************************
  logic [3:0] out_nibble;
  logic       out_step;
  logic [3:0] nxt_rxd;
  logic       nxt_rx_dv;
  logic       nxt_rx_er;
  logic       nxt_dibit_hi;

  assign out_nibble = fifo_rd.err ? (fifo_rd.nibble ^ CORRUPT_MASK) : fifo_rd.nibble;
  assign out_step   = tick && drive_ff;

  // Pins move only on the receive clock fall or the reference tick
  always_comb begin
    nxt_rxd      = rxd_out;
    nxt_rx_dv    = rx_dv_out;
    nxt_rx_er    = rx_er_out;
    nxt_dibit_hi = dibit_hi_ff;
    if (out_step && !strap_ff.rmii_sel) begin
      nxt_rxd   = fifo_rd_valid ? out_nibble : NIBBLE_ZERO;
      nxt_rx_dv = fifo_rd_valid;
      nxt_rx_er = fifo_rd_valid && fifo_rd.err;
    end else if (out_step && dibit_hi_ff) begin
      // RMII high dibit; the nibble leaves the FIFO on this tick
      nxt_rxd      = {2'h0, out_nibble[3:2]};
      nxt_rx_dv    = 1'b1;
      nxt_rx_er    = fifo_rd.err;
      nxt_dibit_hi = 1'b0;
    end else if (out_step) begin
      // RMII low dibit goes first
      nxt_rxd      = fifo_rd_valid ? {2'h0, out_nibble[1:0]} : NIBBLE_ZERO;
      nxt_rx_dv    = fifo_rd_valid;
      nxt_rx_er    = fifo_rd_valid && fifo_rd.err;
      nxt_dibit_hi = fifo_rd_valid;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rxd_out <= NIBBLE_ZERO;
    end else begin
      rxd_out <= nxt_rxd;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_dv_out <= 1'b0;
    end else begin
      rx_dv_out <= nxt_rx_dv;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_er_out <= 1'b0;
    end else begin
      rx_er_out <= nxt_rx_er;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      dibit_hi_ff <= 1'b0;
    end else begin
      dibit_hi_ff <= nxt_dibit_hi;
    end
  end

  // ****************************************************************
  // Carrier sense and collision
  // ****************************************************************
  // Merged carrier holds while the last dibit still stands
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      crs_out <= 1'b0;
    end else if (strap_ff.rmii_sel) begin
      crs_out <= rx_medium_active_in || fifo_rd_valid || dibit_hi_ff || nxt_rx_dv;
    end else begin
      crs_out <= rx_medium_active_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      col_out <= 1'b0;
    end else if (strap_ff.rmii_sel) begin
      col_out <= 1'b0;
    end else begin
      col_out <= !full_duplex_in && tx_medium_active_in && rx_medium_active_in;
    end
  end

endmodule

// ### src/prx_pkg.sv
// Package with constants and carrier types for the PHY receive-side MAC interface
package prx_pkg;

  // ****************************************************************
  // Clock rates and derived cycle counts
  // ****************************************************************
  localparam int unsigned CORE_CLK_HZ   = 100_000_000;
  localparam int unsigned RXCLK_100_HZ  = 25_000_000;
  localparam int unsigned RXCLK_10_HZ   = 2_500_000;
  localparam int unsigned RMII_REF_HZ   = 50_000_000;
  localparam int unsigned RMII_10_RATIO = 10;

  localparam int unsigned CNT_W = 6;

  localparam logic [CNT_W-1:0] MII_HALF_100  = CNT_W'(CORE_CLK_HZ / (2 * RXCLK_100_HZ));
  localparam logic [CNT_W-1:0] MII_HALF_10   = CNT_W'(CORE_CLK_HZ / (2 * RXCLK_10_HZ));
  localparam logic [CNT_W-1:0] RMII_TICK_100 = CNT_W'(CORE_CLK_HZ / RMII_REF_HZ);
  localparam logic [CNT_W-1:0] RMII_TICK_10  = CNT_W'((CORE_CLK_HZ / RMII_REF_HZ) * RMII_10_RATIO);
  localparam logic [CNT_W-1:0] CNT_ZERO      = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE       = 6'h01;

  // ****************************************************************
  // Receive path
  // ****************************************************************
  localparam int unsigned RX_FIFO_DEPTH = 8;
  localparam logic [3:0]  CORRUPT_MASK  = 4'hF;
  localparam logic [3:0]  NIBBLE_ZERO   = 4'h0;

  // ****************************************************************
  // Strap layout and reset values
  // ****************************************************************
  localparam int unsigned STRAP_W          = 8;
  localparam int unsigned STRAP_ADDR_UP_LO = 0;
  localparam int unsigned STRAP_RMII_POS   = 4;
  localparam int unsigned STRAP_XOVER_POS  = 5;
  localparam int unsigned STRAP_LEDCFG_POS = 6;
  localparam int unsigned STRAP_ADDR0_POS  = 7;
  localparam logic [4:0]  PHY_ADDR_DFLT    = 5'h01;
  localparam logic [STRAP_W-1:0] SYNC_RST  = 8'h00;

  typedef struct packed {
    logic [3:0] nibble;
    logic       err;
  } prx_word_t;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic       rmii_sel;
    logic       auto_crossover_strap;
    logic       indicator_config_strap;
  } prx_strap_t;

  localparam prx_strap_t STRAP_RST = '{phy_addr: PHY_ADDR_DFLT, rmii_sel: 1'b0,
                                       auto_crossover_strap: 1'b1, indicator_config_strap: 1'b1};

endpackage

// ### src/prx_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module prx_fifo #(
  parameter int unsigned WIDTH = 5,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_ff != '0);
  assign rd_data_out  = mem_ff[rd_ptr_ff];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_ready_in && rd_valid_out;

  always_ff @(posedge core_clk_in) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10: begin
          count_ff <= count_ff + 1'b1;
        end
        2'b01: begin
          count_ff <= count_ff - 1'b1;
        end
        default: begin
          count_ff <= count_ff;
        end
      endcase
    end
  end

endmodule

// ### tb/prx_mac_model.sv
// MAC-side model: strap pulls on the shared pins and capture of received nibbles
`timescale 1ns/1ps
module prx_mac_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] strap_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_in,
  input  wire logic       rx_clk_in,
  output logic      [7:0] pin_out
);
  logic [4:0] cap_ff [0:31];
  logic [4:0] cnt_ff = 5'h00;
  logic       clk_ff = 1'b0;
  // Released pins settle to their pull levels
  assign pin_out = (drv_in & oe_in) | (strap_in & ~oe_in);
  // Nibble taken at each rising receive clock while valid
  always @(posedge core_clk_in) begin
    clk_ff <= rx_clk_in;
    if (rx_clk_in && !clk_ff && drv_in[4]) begin
      cap_ff[cnt_ff] <= {drv_in[5], drv_in[3:0]};
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
endmodule

// ### tb/prx_mac_rx_assertions.sv
// Checker for the receive-side pin driver
`timescale 1ns/1ps
module prx_rx_chk (
  input wire logic       core_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       rx_medium_active_in,
  input wire logic       tx_medium_active_in,
  input wire logic       speed_100_in,
  input wire logic       full_duplex_in,
  input wire logic       crossover_swap_in,
  input wire logic [3:0] rxd_out,
  input wire logic       rxd_oe_out,
  input wire logic       rx_dv_out,
  input wire logic       rx_er_out,
  input wire logic       crs_out,
  input wire logic       col_out,
  input wire logic       col_oe_out,
  input wire logic       rx_clk_out,
  input wire logic       pair_speed_100_out,
  input wire logic       pair_swap_out,
  input wire logic       rmii_mode_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_hi_lo;
    rx_clk_out[*2] ##1 !rx_clk_out[*2] ##1 rx_clk_out;
  endsequence
  property p_clk_100;
    $rose(rx_clk_out) && speed_100_in && !rmii_mode_out |-> s_hi_lo;
  endproperty
  a_clk_100: assert property (p_clk_100) else $error("bad receive clock");
  property p_clk_rmii; rmii_mode_out |-> !rx_clk_out; endproperty
  a_clk_rmii: assert property (p_clk_rmii) else $error("clock in rmii");
  property p_hold;
    !rmii_mode_out && !$past(sys_rst_in) && !$fell(rx_clk_out)
      |-> $stable(rxd_out) && $stable(rx_dv_out) && $stable(rx_er_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved off clock fall");
  property p_col;
    !$past(sys_rst_in) |-> col_out == ($past(tx_medium_active_in && rx_medium_active_in
      && !full_duplex_in) && !rmii_mode_out);
  endproperty
  a_col: assert property (p_col) else $error("bad collision");
  property p_crs; !rmii_mode_out && !$past(sys_rst_in) |-> crs_out == $past(rx_medium_active_in); endproperty
  a_crs: assert property (p_crs) else $error("bad carrier");
  property p_er_dv; rx_er_out |-> rx_dv_out; endproperty
  a_er_dv: assert property (p_er_dv) else $error("error outside packet");
  property p_idle; !rx_dv_out |-> rxd_out == 4'h0 && !rx_er_out; endproperty
  a_idle: assert property (p_idle) else $error("data without valid");
  property p_speed; !$past(sys_rst_in) |-> pair_speed_100_out == $past(speed_100_in); endproperty
  a_speed: assert property (p_speed) else $error("bad pair speed");
  property p_swap; !$past(sys_rst_in) && pair_swap_out |-> $past(crossover_swap_in); endproperty
  a_swap: assert property (p_swap) else $error("swap without request");
  property p_oe_rst; disable iff (1'b0) sys_rst_in |=> !rxd_oe_out && !col_oe_out; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pins driven in reset");
  property p_oe_run; !$past(sys_rst_in) |-> rxd_oe_out && col_oe_out; endproperty
  a_oe_run: assert property (p_oe_run) else $error("pins not driven");
  property p_rmii_crs; rmii_mode_out && rx_dv_out |-> crs_out; endproperty
  a_rmii_crs: assert property (p_rmii_crs) else $error("merged carrier low");
endmodule
bind prx_mac_rx prx_rx_chk chk_u (.*);

// ### tb/prx_mac_rx_tb_top.sv
// Testbench top for the receive-side pin driver
`timescale 1ns/1ps
module prx_mac_rx_tb_top;
  import prx_pkg::*;
  logic       core_clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic [3:0] sym_nibble_in = 4'h0;
  logic       sym_err_in = 1'b0;
  logic       sym_valid_in = 1'b0;
  logic       rx_medium_active_in = 1'b0;
  logic       tx_medium_active_in = 1'b0;
  logic       speed_100_in = 1'b1;
  logic       full_duplex_in = 1'b0;
  logic       crossover_swap_in = 1'b1;
  logic [7:0] strap = 8'hE0;
  logic [7:0] pin;
  logic [3:0] rxd_in, rxd_out;
  logic       rx_dv_in, rx_er_in, crs_in, col_in, sym_ready_out, rxd_oe_out, rx_dv_out, rx_dv_oe_out;
  logic       rx_er_out, rx_er_oe_out, crs_out, crs_oe_out, col_out, col_oe_out, rx_clk_out;
  logic       pair_speed_100_out, pair_swap_out, rmii_mode_out, indicator_config_strap_out;
  logic [4:0] phy_addr_out;
  logic       seen_full;
  int         mismatches = 0;
  int         compares = 0;
  int         cyc = 0;
  assign {col_in, crs_in, rx_er_in, rx_dv_in, rxd_in} = pin;
  prx_mac_rx dut_u (.*);
  prx_mac_model mac_u (
    .core_clk_in (core_clk_in),
    .strap_in    (strap),
    .drv_in      ({col_out, crs_out, rx_er_out, rx_dv_out, rxd_out}),
    .oe_in       ({col_oe_out, crs_oe_out, rx_er_oe_out, rx_dv_oe_out, {4{rxd_oe_out}}}),
    .rx_clk_in   (rx_clk_out),
    .pin_out     (pin)
  );
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [3:0] n, input logic e);
    sym_valid_in = 1'b1;
    sym_nibble_in = n;
    sym_err_in = e;
    if (!sym_ready_out) seen_full = 1'b1;
    while (!sym_ready_out) @(negedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  task automatic do_reset(input logic [7:0] s, input logic sp);
    strap = s;
    speed_100_in = sp;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    chk({rxd_oe_out, rx_dv_oe_out, rx_er_oe_out, crs_oe_out, col_oe_out}, 5'h00);
    @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    @(negedge core_clk_in);
    chk({rxd_oe_out, rx_dv_oe_out, rx_er_oe_out, crs_oe_out, col_oe_out}, 5'h1F);
  endtask
  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_mii_data();
    logic [3:0] n [4] = '{4'h3, 4'hA, 4'h5, 4'hC};
    logic [4:0] b;
    b = mac_u.cnt_ff;
    for (int i = 0; i < 4; i++) send(n[i], i == 1);
    sym_valid_in = 1'b0;
    repeat (40) @(negedge core_clk_in);
    chk(mac_u.cnt_ff - b, 5'h04);
    for (int i = 0; i < 4; i++) chk(mac_u.cap_ff[b + i], {i == 1, n[i] ^ (i == 1 ? CORRUPT_MASK : 4'h0)});
  endtask
  task automatic t_col();
    tx_medium_active_in = 1'b1;
    rx_medium_active_in = 1'b1;
    @(negedge core_clk_in);
    chk({col_out, crs_out}, 2'h3);
    tx_medium_active_in = 1'b0;
    @(negedge core_clk_in);
    chk({col_out, crs_out}, 2'h1);
    tx_medium_active_in = 1'b1;
    full_duplex_in = 1'b1;
    @(negedge core_clk_in);
    chk({col_out, crs_out}, 2'h1);
    tx_medium_active_in = 1'b0;
    rx_medium_active_in = 1'b0;
    full_duplex_in = 1'b0;
    @(negedge core_clk_in);
    chk({col_out, crs_out}, 2'h0);
  endtask
  task automatic t_clk10();
    int n = 0;
    @(posedge rx_clk_out);
    @(negedge core_clk_in);
    while (rx_clk_out) begin
      n++;
      @(negedge core_clk_in);
    end
    chk(8'(n), MII_HALF_10);
  endtask
  task automatic t_fifo();
    logic [4:0] b;
    b = mac_u.cnt_ff;
    seen_full = 1'b0;
    for (int i = 0; i < 12; i++) send(4'(i), 1'b0);
    sym_valid_in = 1'b0;
    chk(seen_full, 1'b1);
    repeat (600) @(negedge core_clk_in);
    chk(mac_u.cnt_ff - b, 5'h0C);
    for (int i = 0; i < 12; i++) chk(mac_u.cap_ff[b + i], 5'(i));
  endtask
  task automatic t_rmii();
    do_reset(8'hF0, 1'b0);
    chk({rmii_mode_out, phy_addr_out}, 6'h21);
    tx_medium_active_in = 1'b1;
    rx_medium_active_in = 1'b1;
    send(4'h6, 1'b0);
    sym_valid_in = 1'b0;
    while (!rx_dv_out) @(negedge core_clk_in);
    chk({crs_out, col_out, rxd_out}, 6'h22);
    repeat (20) @(negedge core_clk_in);
    chk({rx_dv_out, rxd_out}, 5'h11);
    send(4'h9, 1'b1);
    sym_valid_in = 1'b0;
    while (!rx_er_out) @(negedge core_clk_in);
    chk({rx_dv_out, rx_er_out, rxd_out}, 6'h32);
    repeat (20) @(negedge core_clk_in);
    chk({rx_dv_out, rx_er_out, rxd_out}, 6'h31);
    tx_medium_active_in = 1'b0;
    rx_medium_active_in = 1'b0;
  endtask
  initial begin
    do_reset(8'hE0, 1'b1);
    chk(phy_addr_out, 5'h01);
    chk({rmii_mode_out, indicator_config_strap_out, pair_swap_out}, 3'h3);
    t_mii_data();
    t_col();
    do_reset(8'h0D, 1'b0);
    chk(phy_addr_out, 5'h1A);
    chk({indicator_config_strap_out, pair_swap_out, pair_speed_100_out}, 3'h0);
    t_clk10();
    t_fifo();
    t_rmii();
    finish_test();
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end
endmodule
